// ==== mivu_defs.vh ====
`ifndef MIVU_DEFS_VH
`define MIVU_DEFS_VH

// low six address bits select the register inside each channel window
`define MIVU_OFS_GLOBAL 6'h38
`define MIVU_OFS_PORT_SETUP 6'h39
`define MIVU_OFS_CHAN_STAT0 6'h3a
`define MIVU_OFS_CHAN_STAT1 6'h3b

// reset values
`define MIVU_RST_VECTOR_BASE 8'h00
`define MIVU_RST_PORT_SETUP 8'h00

// vector base setup fields
`define MIVU_VB_HIGH_MSB 7
`define MIVU_VB_HIGH_LSB 6
`define MIVU_VB_BIT5 5
`define MIVU_VB_EXT_MSB 4
`define MIVU_VB_EXT_LSB 2
`define MIVU_VB_CYCLIC 1
`define MIVU_VB_EXT_SEL 0

// irq port setup fields
`define MIVU_PS_SHOW_MASKED 7
`define MIVU_PS_SEVEN_ADJ 6
`define MIVU_PS_MEMBER_MSB 5
`define MIVU_PS_MEMBER_LSB 3
`define MIVU_PS_CHAINING 2
`define MIVU_PS_OUT_MSB 1
`define MIVU_PS_OUT_LSB 0

// vector bit naming the status register of the source
`define MIVU_VEC_REG_SEL 1

`endif

// ==== mivu_host_model.sv ====
`timescale 1ns/100ps
module mivu_host_model (
  input wire i_core_clk,
  input wire [7:0] i_data,
  input wire i_oe,
  input wire [1:0] i_slow,
  output reg [8:0] o_addr,
  output reg o_cs_n,
  output reg o_rd_n,
  output reg o_wr_n,
  output reg o_irq_ack_cycle_n,
  output reg [7:0] o_data
);
  initial {o_addr, o_cs_n, o_rd_n, o_wr_n, o_irq_ack_cycle_n, o_data} = {9'h0, 4'hf, 8'h0};
  task wr(input [8:0] a, input [7:0] d);
    begin
      @(posedge i_core_clk);
      {o_addr, o_data, o_cs_n, o_wr_n} <= {a, d, 2'b00};
      repeat (1 + i_slow) @(posedge i_core_clk);
      o_wr_n <= 1'b1;
      @(posedge i_core_clk);
      // released bus must not look like held data
      {o_cs_n, o_data} <= {1'b1, ~d};
    end
  endtask
  task rd(input [8:0] a, output [8:0] q);
    begin
      @(posedge i_core_clk);
      {o_addr, o_cs_n, o_rd_n} <= {a, 2'b00};
      repeat (2 + i_slow) @(posedge i_core_clk);
      q = {i_oe, i_data};
      {o_cs_n, o_rd_n} <= 2'b11;
    end
  endtask
  task ack(output [8:0] q);
    begin
      @(posedge i_core_clk);
      o_irq_ack_cycle_n <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      q = {i_oe, i_data};
      o_irq_ack_cycle_n <= 1'b1;
      repeat (2) @(posedge i_core_clk);
    end
  endtask
endmodule // mivu_host_model

// ==== mivu_monitor.sv ====
`timescale 1ns/100ps
module mivu_monitor (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire [8:0] i_addr,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire i_irq_ack_cycle_n,
  input wire [63:0] i_chan_stat0,
  input wire [63:0] i_chan_stat1,
  input wire [63:0] i_chan_mask0,
  input wire [63:0] i_chan_mask1,
  input wire [3:0] i_port_pend,
  input wire [7:0] o_data,
  input wire o_data_oe,
  input wire o_vec_done,
  input wire o_chain_out,
  input wire o_chain_out_oe
);
  wire rd_req = !i_cs_n && !i_rd_n && i_irq_ack_cycle_n;
  wire pend = |((i_chan_stat0 & ~i_chan_mask0) | (i_chan_stat1 & ~i_chan_mask1));
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_ack_end;
    o_data_oe && !i_irq_ack_cycle_n ##1 i_irq_ack_cycle_n;
  endsequence
  a_global_read: assert property (rd_req && i_addr[5:0] == 6'h38 |=> o_data_oe)
    else $error("global read silent");
  a_unmapped_quiet: assert property (rd_req && i_addr[5:1] != 5'h1c |=> !o_data_oe)
    else $error("unmapped read driven");
  a_ack_end: assert property (s_ack_end |=> o_vec_done && !o_data_oe)
    else $error("ack end missed");
  a_done_pulse: assert property (o_vec_done |=> !o_vec_done)
    else $error("done too long");
  a_vector_lsb: assert property (!i_irq_ack_cycle_n ##1 !i_irq_ack_cycle_n && o_data_oe |-> !o_data[0])
    else $error("vector bit 0 set");
  a_no_pend_quiet: assert property (i_irq_ack_cycle_n ##1 !i_irq_ack_cycle_n && !pend && !(|i_port_pend)
    |=> !o_data_oe) else $error("vector without source");
  a_chain_low: assert property ((o_chain_out_oe && pend)[*3] |-> !o_chain_out)
    else $error("chain out high");
  a_bus_idle: assert property ((i_rd_n && i_irq_ack_cycle_n)[*2] |-> !o_data_oe)
    else $error("bus driven idle");
endmodule // mivu_monitor

bind mivu_vector_unit mivu_monitor u_mon (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_irq_ack_cycle_n(i_irq_ack_cycle_n),
  .i_chan_stat0(i_chan_stat0), .i_chan_stat1(i_chan_stat1), .i_chan_mask0(i_chan_mask0),
  .i_chan_mask1(i_chan_mask1), .i_port_pend(i_port_pend), .o_data(o_data),
  .o_data_oe(o_data_oe), .o_vec_done(o_vec_done), .o_chain_out(o_chain_out),
  .o_chain_out_oe(o_chain_out_oe));

// ==== mivu_vector_unit.v ====
`timescale 1ns/100ps
`include "mivu_defs.vh"

// How it works
// - four port pending flags follow the port status inputs, apart from channels
// - any_channel_pending set when any unmasked channel source is active
// - top_channel_number gives highest-priority pending channel while any_channel_pending
// - global status frozen: first read after vector, channel status reads, acknowledge
// - global status readable at every channel alias, identical contents
// - writing vector base at a channel alias makes that channel highest priority
// - new priority applies at write strobe rising edge, held until next write, or when rotating until next service
// - acknowledge drives vector; bits 7 and 6 from programmed high bits
// - vector bit 5 from programmed bit in extended mode, always on version one
// - extended mode puts programmed extension bits on vector bits 2 to 4
// - extended mode: bits 2..5 programmed; otherwise channel number on bits 2..4
// - priority mode 0 keeps order fixed, 1 readjusts after each service
// - rotating: all eight rotate, or seven rotate with one fixed on top
// - masked-visibility bit passed to channels to show or hide masked status
// - irq port setup readable and writable at every channel alias
// - slave cascade: acknowledge taken only when pending and pins match identity
// - daisy chain: needs pending and enable in; enable out low on interrupt
// - output type: low bit 0 open drain, 01 active-low, 11 active-high
// - masked sources give no vector, no interrupt pin, no global status
module mivu_vector_unit #(
  parameter VERSION_ONE = 0
) (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  input wire [8:0] i_addr,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire [7:0] i_data,
  output reg [7:0] o_data,
  output reg o_data_oe,
  input wire i_irq_ack_cycle_n,
  input wire [63:0] i_chan_stat0,
  input wire [63:0] i_chan_stat1,
  input wire [63:0] i_chan_mask0,
  input wire [63:0] i_chan_mask1,
  input wire [3:0] i_port_pend,
  output reg o_show_masked,
  output reg o_vec_done,
  output reg [2:0] o_vec_chan,
  output reg o_irq,
  output reg o_irq_oe,
  input wire [2:0] i_casc,
  output reg o_chain_out,
  output reg o_chain_out_oe
);

  reg [7:0] vector_base_reg;
  reg [7:0] port_setup_reg;
  reg [7:0] global_reg;
  reg [2:0] top_chan_reg;
  reg [2:0] rot_start_reg;
  reg wr_n_d_reg;
  reg wr_hit_reg;
  reg irq_ack_cycle_n_d_reg;
  reg [8:0] wr_addr_reg;
  reg [7:0] wr_data_reg;
  reg vec_seen_reg;
  reg gis_read_hold_reg;
  reg ack_taken_reg;
  reg [2:0] ack_chan_reg;

  reg [7:0] pend0;
  reg [7:0] pend1;
  reg [7:0] pend;
  integer k;

  always @* begin
    pend0 = 8'h00;
    pend1 = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      pend0[k] = |(i_chan_stat0[k*8 +: 8] & ~i_chan_mask0[k*8 +: 8]);
      pend1[k] = |(i_chan_stat1[k*8 +: 8] & ~i_chan_mask1[k*8 +: 8]);
    end
    pend = pend0 | pend1;
  end

  // cyclic scan from start; optional fixed channel always checked first
  function [2:0] pick;
    input [7:0] req;
    input [2:0] start;
    input fix_en;
    input [2:0] fix;
    integer i;
    reg found;
    reg [2:0] c;
    begin
      pick = start;
      found = 1'b0;
      if (fix_en && req[fix]) begin
        pick = fix;
        found = 1'b1;
      end
      for (i = 0; i < 8; i = i + 1) begin
        c = start + i[2:0];
        if (!found && req[c] && !(fix_en && c == fix)) begin
          pick = c;
          found = 1'b1;
        end
      end
    end
  endfunction

  wire cyclic = vector_base_reg[`MIVU_VB_CYCLIC];
  wire seven = port_setup_reg[`MIVU_PS_SEVEN_ADJ];
  wire ext_sel = vector_base_reg[`MIVU_VB_EXT_SEL];
  wire chaining = port_setup_reg[`MIVU_PS_CHAINING];
  wire [1:0] out_type = port_setup_reg[`MIVU_PS_OUT_MSB:`MIVU_PS_OUT_LSB];
  wire [2:0] member_id = port_setup_reg[`MIVU_PS_MEMBER_MSB:`MIVU_PS_MEMBER_LSB];

  // seven-channel variant pins the written channel on top
  // cyclic ascending order from the top channel, or from the rotation point when rotating
  wire [2:0] best_chan = !cyclic ? pick(pend, top_chan_reg, 1'b0, top_chan_reg)
                                 : pick(pend, rot_start_reg, seven, top_chan_reg);

  wire any_chan = |pend;

  wire sel = !i_cs_n;
  wire rd_act = sel && !i_rd_n;
  wire [5:0] ofs = i_addr[5:0];
  wire rd_global = rd_act && ofs == `MIVU_OFS_GLOBAL;
  wire rd_chan_stat = rd_act && (ofs == `MIVU_OFS_CHAN_STAT0 || ofs == `MIVU_OFS_CHAN_STAT1);

  wire ack_ok = any_chan && (chaining ? i_casc[1] : i_casc == member_id);
  wire ack_start = !i_irq_ack_cycle_n && irq_ack_cycle_n_d_reg && ack_ok;
  wire ack_now = !i_irq_ack_cycle_n && (ack_taken_reg || ack_start);

  wire freeze = !i_irq_ack_cycle_n || rd_chan_stat || (rd_global && (vec_seen_reg || gis_read_hold_reg));

  // a strobe seen without select must not commit stale address or data
  wire wr_end = !wr_n_d_reg && i_wr_n && wr_hit_reg;
  wire wr_base_end = wr_end && wr_addr_reg[5:0] == `MIVU_OFS_GLOBAL;
  wire wr_setup_end = wr_end && wr_addr_reg[5:0] == `MIVU_OFS_PORT_SETUP;
  wire ack_end = !irq_ack_cycle_n_d_reg && i_irq_ack_cycle_n && ack_taken_reg;

  reg [7:0] vector;
  always @* begin
    vector = 8'h00;
    vector[`MIVU_VB_HIGH_MSB:`MIVU_VB_HIGH_LSB] =
      vector_base_reg[`MIVU_VB_HIGH_MSB:`MIVU_VB_HIGH_LSB];
    if (ext_sel) begin
      vector[`MIVU_VB_EXT_MSB:`MIVU_VB_EXT_LSB] =
        vector_base_reg[`MIVU_VB_EXT_MSB:`MIVU_VB_EXT_LSB];
    end else begin
      vector[`MIVU_VB_EXT_MSB:`MIVU_VB_EXT_LSB] = global_reg[2:0];
    end
    if (ext_sel || VERSION_ONE != 0) begin
      vector[`MIVU_VB_BIT5] = vector_base_reg[`MIVU_VB_BIT5];
    end
    // second status register only when first is clear
    vector[`MIVU_VEC_REG_SEL] = !pend0[global_reg[2:0]];
  end

  // setup registers; commit only on the strobe's rising edge
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vector_base_reg <= `MIVU_RST_VECTOR_BASE;
      port_setup_reg <= `MIVU_RST_PORT_SETUP;
      top_chan_reg <= 3'h0;
      wr_n_d_reg <= 1'b1;
      wr_hit_reg <= 1'b0;
      wr_addr_reg <= 9'h000;
      wr_data_reg <= 8'h00;
    end else if (i_clk_en) begin
      wr_n_d_reg <= i_wr_n;
      // capture while strobe low, commit on its rising edge
      if (sel && !i_wr_n) begin
        wr_hit_reg <= 1'b1;
        wr_addr_reg <= i_addr;
        wr_data_reg <= i_data;
      end else if (i_wr_n) begin
        wr_hit_reg <= 1'b0;
      end
      if (wr_base_end) begin
        // unused bits stored as written, host keeps them zero
        vector_base_reg <= wr_data_reg;
        top_chan_reg <= wr_addr_reg[8:6];
      end
      if (wr_setup_end) begin
        port_setup_reg <= wr_data_reg;
      end
    end
  end

  // global status, acknowledge tracking and rotation point
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      global_reg <= 8'h00;
      rot_start_reg <= 3'h0;
      irq_ack_cycle_n_d_reg <= 1'b1;
      vec_seen_reg <= 1'b0;
      gis_read_hold_reg <= 1'b0;
      ack_taken_reg <= 1'b0;
      ack_chan_reg <= 3'h0;
      o_vec_done <= 1'b0;
      o_vec_chan <= 3'h0;
    end else if (i_clk_en) begin
      irq_ack_cycle_n_d_reg <= i_irq_ack_cycle_n;
      if (!freeze) begin
        global_reg <= {i_port_pend[0], i_port_pend[1], i_port_pend[2], i_port_pend[3],
                       any_chan, any_chan ? best_chan : 3'h0};
      end

      // only the first global read after a vector freezes; held for the read
      if (rd_global && vec_seen_reg) begin
        gis_read_hold_reg <= 1'b1;
        vec_seen_reg <= 1'b0;
      end else if (!rd_global) begin
        gis_read_hold_reg <= 1'b0;
      end

      if (ack_start) begin
        ack_taken_reg <= 1'b1;
        ack_chan_reg <= global_reg[2:0];
      end
      o_vec_done <= 1'b0;
      if (ack_end) begin
        ack_taken_reg <= 1'b0;
        vec_seen_reg <= 1'b1;
        o_vec_done <= 1'b1;
        o_vec_chan <= ack_chan_reg;
      end

      // served channel drops to the bottom
      if (ack_end && cyclic) begin
        rot_start_reg <= ack_chan_reg + 3'h1;
      end else if (wr_base_end) begin
        // rotation restarts at the written channel
        rot_start_reg <= wr_addr_reg[8:6];
      end
    end
  end

  // data bus: vector has priority over a register read
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else if (i_clk_en) begin
      // same global contents at all aliases
      if (ack_now) begin
        o_data <= vector;
        o_data_oe <= 1'b1;
      end else if (rd_global) begin
        o_data <= global_reg;
        o_data_oe <= 1'b1;
      end else if (rd_act && ofs == `MIVU_OFS_PORT_SETUP) begin
        o_data <= port_setup_reg;
        o_data_oe <= 1'b1;
      end else begin
        o_data <= 8'h00;
        o_data_oe <= 1'b0;
      end
    end
  end

  // pins follow the setup one cycle later
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_show_masked <= 1'b0;
      o_irq <= 1'b0;
      o_irq_oe <= 1'b0;
      o_chain_out <= 1'b0;
      o_chain_out_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_show_masked <= port_setup_reg[`MIVU_PS_SHOW_MASKED];

      case (out_type)
        2'b01: begin
          o_irq <= !any_chan;
          o_irq_oe <= 1'b1;
        end
        2'b11: begin
          o_irq <= any_chan;
          o_irq_oe <= 1'b1;
        end
        default: begin
          o_irq <= 1'b0;
          o_irq_oe <= any_chan;
        end
      endcase

      // enable out drops as soon as this device interrupts
      o_chain_out <= chaining && i_casc[1] && !any_chan;
      o_chain_out_oe <= chaining;
    end
  end

endmodule // mivu_vector_unit

// ==== multichannel_interrupt_vector_unit_tb.sv ====
`timescale 1ns/100ps
module multichannel_interrupt_vector_unit_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] slow = 2'b00;
  reg [63:0] s0 = 64'h0, s1 = 64'h0, m0 = 64'h0, m1 = 64'h0;
  reg [3:0] pp = 4'h0;
  reg [2:0] casc = 3'h0;
  reg [31:0] seed = 32'h4e28be88;
  reg [8:0] got;
  reg [7:0] b, v, e;
  integer error_cnt = 0, total_checks = 0, cyc = 0, i, c;
  wire [8:0] addr;
  wire [7:0] wd, rdat;
  wire [2:0] vch;
  wire cs_n, rd_n, wr_n, irq_ack_cycle_n, oe, show, done, irq, irq_oe, cho, cho_oe;
  initial forever #4 clk = ~clk;
  mivu_host_model u_host (.i_core_clk(clk), .i_data(rdat), .i_oe(oe), .i_slow(slow),
    .o_addr(addr), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_irq_ack_cycle_n(irq_ack_cycle_n),
    .o_data(wd));
  mivu_vector_unit u_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
    .i_addr(addr), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(wd),
    .o_data(rdat), .o_data_oe(oe), .i_irq_ack_cycle_n(irq_ack_cycle_n), .i_chan_stat0(s0),
    .i_chan_stat1(s1), .i_chan_mask0(m0), .i_chan_mask1(m1), .i_port_pend(pp),
    .o_show_masked(show), .o_vec_done(done), .o_vec_chan(vch), .o_irq(irq),
    .o_irq_oe(irq_oe), .i_casc(casc), .o_chain_out(cho), .o_chain_out_oe(cho_oe));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [63:0] r64(input d);
    begin
      seed = xs(xs(seed));
      r64 = {seed, xs(seed)};
    end
  endfunction
  function [7:0] global_pending_status(input [2:0] top);
    integer k;
    reg [2:0] n;
    begin
      global_pending_status = {pp[0], pp[1], pp[2], pp[3], 4'h0};
      for (k = 7; k >= 0; k = k - 1) begin
        n = top + k[2:0];
        if (|((s0[8*n+:8] & ~m0[8*n+:8]) | (s1[8*n+:8] & ~m1[8*n+:8])))
          global_pending_status[3:0] = {1'b1, n};
      end
    end
  endfunction
  task chk(input [8:0] g, input [8:0] x);
    begin
      total_checks = total_checks + 1;
      if (g !== x) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      slow <= seed[9:8];
      u_host.wr({i[2:0], 6'h39}, seed[7:0]);
      u_host.rd({i[2:0] + 3'd3, 6'h39}, got);
      chk(got, {1'b1, seed[7:0]});
      chk({show, 8'h0}, {seed[7], 8'h0});
    end
    for (i = 0; i < 40; i = i + 1) begin
      seed = xs(seed);
      c = seed[2:0];
      u_host.wr({seed[2:0], 6'h38}, {seed[15:10], 2'b00});
      pp <= seed[19:16];
      s0 <= r64(0) & r64(0) & r64(0);
      // all masked now and then: sources must vanish from status
      m0 <= i[2:0] == 3'd0 ? ~64'h0 : r64(0);
      repeat (3) @(posedge clk);
      e = global_pending_status(c[2:0]);
      u_host.rd({seed[22:20], 6'h38}, got);
      chk(e[3] ? got : got & 9'h1f8, {1'b1, e});
    end
    pp <= 4'h0;
    m0 <= 64'h0;
    u_host.wr(9'h079, 8'h29);
    for (i = 0; i < 12; i = i + 1) begin
      seed = xs(seed);
      c = seed[2:0];
      b = {seed[15:10], 1'b0, seed[16]};
      u_host.wr({seed[22:20], 6'h38}, b);
      s0 <= seed[17] ? 64'h0 : 64'h1 << 8 * c;
      s1 <= 64'h80 << 8 * c;
      casc <= i[1:0] == 2'd3 ? 3'd4 : 3'd5;
      repeat (3) @(posedge clk);
      chk({7'h0, irq_oe, irq}, 9'h2);
      u_host.ack(got);
      v = {b[7:6], b[0] ? b[5:2] : {1'b0, c[2:0]}, seed[17], 1'b0};
      chk(got & {1'b1, {8{got[8]}}}, i[1:0] == 2'd3 ? 9'h0 : {1'b1, v});
      if (i[1:0] != 2'd3)
        chk({5'h0, done, vch}, {5'h1, c[2:0]});
    end
    for (i = 0; i < 3; i = i + 1) begin
      u_host.wr(9'h0b9, {6'h01, i[1:0] + {1'b0, i[1]}});
      casc <= {1'b0, i[0], 1'b0};
      repeat (3) @(posedge clk);
      chk({5'h0, irq_oe, irq, cho_oe, cho}, {5'h0, 1'b1, i[1], 2'b10});
      u_host.ack(got);
      chk({8'h0, got[8]}, {8'h0, i[0]});
    end
    s0 <= ~64'h0;
    casc <= 3'd0;
    for (i = 0; i < 2; i = i + 1) begin
      u_host.wr(9'h039, {1'b0, i[0], 6'h0});
      // vector base at alias 0 then 3 with only the rotating priority bit set
      u_host.wr({1'b0, i[0], i[0], 6'h38}, 8'h02);
      u_host.ack(got);
      chk({6'h0, vch}, {7'h0, i[0], i[0]});
      u_host.rd(9'h038, got);
      chk({6'h0, got[2:0]}, {6'h0, i[0] ? 3'd3 : 3'd1});
    end
    {s0, s1} <= 128'h0;
    u_host.rd(9'h1ff, got);
    chk({8'h0, got[8]}, 9'h0);
    u_host.ack(got);
    chk({8'h0, got[8]}, 9'h0);
    chk({7'h0, irq_oe, irq}, 9'h0);
    end_of_test;
  end
endmodule // multichannel_interrupt_vector_unit_tb
